/* rtl/tcc_pkg.sv */
// Purpose: constants and carrier types of the capture/compare timer
// Assumes: one 25 MHz clock, APB register access, 32-bit data
// Notes: all offsets are byte addresses of aligned words
// ==========================================================================
package tcc_pkg;
    // ======================================================================
    // register map
    localparam logic [7:0] ADDR_CTRL_ONE = 8'h00; // timer_control_one
    localparam logic [7:0] ADDR_CTRL_TWO = 8'h04; // timer_control_two
    localparam logic [7:0] ADDR_PRESCALE = 8'h08; // prescaler_select_reg
    localparam logic [7:0] ADDR_CAP_CTRL = 8'h0C; // clear and capture options
    localparam logic [7:0] ADDR_EDGE = 8'h10; // edge_mode_reg
    localparam logic [7:0] ADDR_CMP_A = 8'h14; // compare_a
    localparam logic [7:0] ADDR_CMP_B = 8'h18; // dual_compare_capture_b
    localparam logic [7:0] ADDR_CAP_C = 8'h1C; // capture_c, read only
    localparam logic [7:0] ADDR_COUNT = 8'h20; // timer_count, read only
    localparam logic [7:0] ADDR_STATUS = 8'h24; // event flags, write one clears
    // ======================================================================
    // field positions
    localparam int RUN_BIT = 3; // count_run_bit
    localparam int SHOT_BIT = 5; // single_shot_select
    localparam int FULL_BIT = 6; // full_count_flag
    localparam int WIDTH_BIT = 0; // width_select
    localparam int BSEL_BIT = 0; // b_capture_select
    localparam int CLRB_BIT = 1; // clear_after_b
    localparam int CLRC_BIT = 2; // clear_after_c
    localparam int CLRA_BIT = 3; // clear on compare_a match
    localparam int EDGE_B_LSB = 0; // edge code of event_trigger_pin_b
    localparam int EDGE_C_LSB = 2; // edge code of capture_trigger_pin_c
    localparam int ST_MATCH_A = 0;
    localparam int ST_MATCH_B = 1;
    localparam int ST_EXT_B = 2;
    localparam int ST_EXT_C = 3;
    // ======================================================================
    // encodings and counts
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1; // codes 2 and 3 both mean both edges
    localparam logic [3:0] PRESC_EXT = 4'hF; // external event source
    localparam logic [3:0] PRESC_MAX = 4'h8; // divide by 2048
    localparam int PRESC_BASE = 3; // smallest divide is 2**3
    localparam int PRESC_W = 11;
    localparam int SYNC_N = 3;
    localparam logic [15:0] ONES_WIDE = 16'hFFFF;
    localparam logic [15:0] ONES_NARROW = 16'h00FF;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    // ======================================================================
    // carriers
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } tcc_apb_req_t;
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tcc_apb_rsp_t;
    typedef struct packed {
        logic match_a; // match pulse to output control
        logic match_b;
        logic irq_a; // match_irq_a
        logic irq_b; // match_irq_b
        logic full; // full count notice to output control
        logic ext_b; // event pin request
        logic ext_c; // capture pin request
    } tcc_evt_t;
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] cmp_a;
        logic [15:0] cmp_b;
        logic [15:0] cap_c;
        logic run;
        logic one_shot;
        logic full_flag;
        logic wide;
        logic [3:0] presc_sel;
        logic [3:0] cap_cfg;
        logic [3:0] edge_cfg;
        logic [3:0] status;
        logic start_pend; // first tick after start loads zero
        logic clr_pend; // match clear waits for tick
        logic capclr_pend; // capture clear waits for tick
        logic zero_now; // momentary plus-one shown, zero next
        logic fresh; // count took a new value last cycle
        logic [PRESC_W-1:0] presc;
        logic [SYNC_N-1:0] sync_b;
        logic [SYNC_N-1:0] sync_c;
        logic level_b;
        logic level_c;
        tcc_apb_rsp_t rsp;
        tcc_evt_t evt;
    } tcc_state_t;
endpackage

/* rtl/tcc_timer.sv */
// Purpose: up counter, 8 or 16 bits, with compare, capture and event input
// Assumes: pins are asynchronous; APB master waits for pready
// Notes: every output is a field of the registered state
module tcc_timer #(
    parameter int PRESC_W = tcc_pkg::PRESC_W
) (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire tcc_pkg::tcc_apb_req_t I_APB_REQ,
    output tcc_pkg::tcc_apb_rsp_t O_APB_RSP,
    input wire logic I_EVENT_CLOCK_IN, // event_trigger_pin_b, shared
    input wire logic I_CAPTURE_TRIGGER_PIN_C,
    output tcc_pkg::tcc_evt_t O_EVENTS,
    output logic [15:0] O_TIMER_COUNT
);
    // ======================================================================
    // elaboration check
    generate
        if (PRESC_W != tcc_pkg::PRESC_W) begin : g_bad
            $error("prescaler width must match the divide table");
        end
    endgenerate

    // ======================================================================
    // helpers
    // edge code decode, shared by both pins
    function automatic logic edge_hit(input logic [1:0] cfg, input logic rise,
                                      input logic fall);
        case (cfg)
            tcc_pkg::EDGE_FALL: edge_hit = fall;
            tcc_pkg::EDGE_RISE: edge_hit = rise;
            default: edge_hit = rise | fall;
        endcase
    endfunction

    // all-ones value for the selected width
    function automatic logic [15:0] ones_of(input logic wide);
        ones_of = wide ? tcc_pkg::ONES_WIDE : tcc_pkg::ONES_NARROW;
    endfunction

    // ======================================================================
    // state
    tcc_pkg::tcc_state_t r; // registered state
    tcc_pkg::tcc_state_t next_r; // next state

    // ======================================================================
    // next-state logic
    // one process holds all behaviour so that priorities stay visible
    always_comb begin
        logic rise_b;
        logic fall_b;
        logic rise_c;
        logic fall_c;
        logic trig_b; // valid edge on event pin
        logic trig_c; // valid edge on capture pin
        logic tick; // count enable for this cycle
        logic [3:0] sel;
        logic [PRESC_W-1:0] pmask;
        logic [15:0] ones;
        logic [15:0] inc;
        logic wr;
        logic rd;
        logic wr_ctrl;
        logic start_wr;
        logic stop_wr;
        logic flag_clr;
        logic set_full;
        logic hit_a;
        logic hit_b;
        logic [3:0] st_set;
        logic [3:0] st_clr;
        logic [31:0] rdata;
        logic known;
        rise_b = 1'b0;
        fall_b = 1'b0;
        rise_c = 1'b0;
        fall_c = 1'b0;
        trig_b = 1'b0;
        trig_c = 1'b0;
        tick = 1'b0;
        sel = r.presc_sel;
        pmask = '0;
        ones = ones_of(r.wide);
        inc = (r.count + tcc_pkg::CNT_ONE) & ones;
        set_full = 1'b0;
        hit_a = 1'b0;
        hit_b = 1'b0;
        st_set = 4'h0;
        st_clr = 4'h0;
        rdata = 32'h0000_0000;
        known = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        wr_ctrl = 1'b0;
        start_wr = 1'b0;
        stop_wr = 1'b0;
        flag_clr = 1'b0;
        next_r = r;
        next_r.evt = '0;
        next_r.fresh = 1'b0;

        // --- pin synchronisers: a change counts once stages two and three agree
        next_r.sync_b = {r.sync_b[tcc_pkg::SYNC_N-2:0], I_EVENT_CLOCK_IN};
        next_r.sync_c = {r.sync_c[tcc_pkg::SYNC_N-2:0], I_CAPTURE_TRIGGER_PIN_C};
        if (r.sync_b[1] == r.sync_b[2] && r.sync_b[2] != r.level_b) begin
            next_r.level_b = r.sync_b[2];
            rise_b = r.sync_b[2];
            fall_b = ~r.sync_b[2];
        end
        if (r.sync_c[1] == r.sync_c[2] && r.sync_c[2] != r.level_c) begin
            next_r.level_c = r.sync_c[2];
            rise_c = r.sync_c[2];
            fall_c = ~r.sync_c[2];
        end
        // both-edge filtering needs two clocks per level, so the pin
        // tolerates up to a clock over four
        trig_b = edge_hit(r.edge_cfg[tcc_pkg::EDGE_B_LSB +: 2], rise_b, fall_b);
        trig_c = edge_hit(r.edge_cfg[tcc_pkg::EDGE_C_LSB +: 2], rise_c, fall_c);
        st_set[tcc_pkg::ST_EXT_B] = trig_b;
        st_set[tcc_pkg::ST_EXT_C] = trig_c;
        next_r.evt.ext_b = trig_b;
        next_r.evt.ext_c = trig_c;

        // --- count enable: free prescaler or event edge, one cycle wide
        next_r.presc = r.presc + 1'b1;
        if (sel == tcc_pkg::PRESC_EXT) begin
            tick = trig_b;
        end else begin
            if (sel > tcc_pkg::PRESC_MAX) begin
                sel = tcc_pkg::PRESC_MAX;
            end
            pmask = PRESC_W'((1 << (int'(sel) + tcc_pkg::PRESC_BASE)) - 1);
            tick = ((r.presc & pmask) == pmask);
        end

        // --- bus decode; writes land at the edge where pready is seen
        wr = I_APB_REQ.psel & I_APB_REQ.penable & r.rsp.pready & I_APB_REQ.pwrite;
        rd = I_APB_REQ.psel & I_APB_REQ.penable & ~r.rsp.pready;
        wr_ctrl = wr && (I_APB_REQ.paddr == tcc_pkg::ADDR_CTRL_ONE);
        start_wr = wr_ctrl & I_APB_REQ.pwdata[tcc_pkg::RUN_BIT] & ~r.run;
        stop_wr = wr_ctrl & ~I_APB_REQ.pwdata[tcc_pkg::RUN_BIT] & r.run;
        flag_clr = wr_ctrl & ~I_APB_REQ.pwdata[tcc_pkg::FULL_BIT] & r.full_flag;

        // --- counter
        if (!r.run) begin
            // stopped: held at zero; the start write arms a zero load
            next_r.count = tcc_pkg::CNT_ZERO;
            next_r.clr_pend = 1'b0;
            next_r.capclr_pend = 1'b0;
            next_r.zero_now = 1'b0;
            next_r.start_pend = start_wr;
        end else if (stop_wr) begin
            next_r.count = tcc_pkg::CNT_ZERO;
            next_r.start_pend = 1'b0;
            next_r.clr_pend = 1'b0;
            next_r.capclr_pend = 1'b0;
            next_r.zero_now = 1'b0;
        end else if (flag_clr && r.one_shot) begin
            // single shot restart: zero now, count on the next tick
            next_r.count = tcc_pkg::CNT_ZERO;
            next_r.clr_pend = 1'b0;
            next_r.capclr_pend = 1'b0;
            next_r.zero_now = 1'b0;
            next_r.fresh = 1'b1;
        end else if (r.zero_now) begin
            next_r.count = tcc_pkg::CNT_ZERO;
            next_r.zero_now = 1'b0;
            next_r.fresh = 1'b1;
        end else if (tick) begin
            if (r.start_pend) begin
                next_r.count = tcc_pkg::CNT_ZERO;
                next_r.start_pend = 1'b0;
                next_r.fresh = 1'b1;
            end else if (r.capclr_pend) begin
                // the plus-one value is visible for one cycle and can match
                next_r.count = inc;
                next_r.capclr_pend = 1'b0;
                next_r.clr_pend = 1'b0;
                next_r.zero_now = 1'b1;
                next_r.fresh = 1'b1;
            end else if (r.clr_pend) begin
                next_r.count = tcc_pkg::CNT_ZERO;
                next_r.clr_pend = 1'b0;
                next_r.fresh = 1'b1;
            end else if (r.one_shot && r.full_flag) begin
                next_r.count = r.count;
            end else if (r.count == ones) begin
                if (!r.one_shot) begin
                    next_r.count = tcc_pkg::CNT_ZERO;
                    set_full = 1'b1;
                    next_r.evt.full = 1'b1;
                    next_r.fresh = 1'b1;
                end else begin
                    set_full = 1'b1;
                end
            end else begin
                next_r.count = inc;
                next_r.fresh = 1'b1;
                if (r.one_shot && inc == ones) begin
                    set_full = 1'b1;
                    next_r.evt.full = 1'b1;
                end
            end
        end

        // --- compare and capture, only while running
        if (r.run && !stop_wr) begin
            hit_a = r.fresh && ((r.count & ones) == (r.cmp_a & ones));
            hit_b = r.fresh && !r.cap_cfg[tcc_pkg::BSEL_BIT]
                && ((r.count & ones) == (r.cmp_b & ones));
            if ((hit_a && r.cap_cfg[tcc_pkg::CLRA_BIT])
                || (hit_b && r.cap_cfg[tcc_pkg::CLRB_BIT])) begin
                next_r.clr_pend = 1'b1;
            end
            if (trig_c) begin
                next_r.cap_c = r.count;
                if (r.cap_cfg[tcc_pkg::CLRC_BIT]) begin
                    next_r.capclr_pend = 1'b1;
                end
            end
            if (trig_b && r.cap_cfg[tcc_pkg::BSEL_BIT]) begin
                next_r.cmp_b = r.count;
                if (r.cap_cfg[tcc_pkg::CLRB_BIT]) begin
                    next_r.capclr_pend = 1'b1;
                end
            end
        end
        next_r.evt.match_a = hit_a;
        next_r.evt.irq_a = hit_a;
        next_r.evt.match_b = hit_b;
        next_r.evt.irq_b = hit_b;
        st_set[tcc_pkg::ST_MATCH_A] = hit_a;
        st_set[tcc_pkg::ST_MATCH_B] = hit_b;

        // --- register writes; hardware sets win over software clears
        if (wr) begin
            case (I_APB_REQ.paddr)
                tcc_pkg::ADDR_CTRL_ONE: begin
                    next_r.run = I_APB_REQ.pwdata[tcc_pkg::RUN_BIT];
                    next_r.one_shot = I_APB_REQ.pwdata[tcc_pkg::SHOT_BIT];
                end
                tcc_pkg::ADDR_CTRL_TWO: next_r.wide = I_APB_REQ.pwdata[tcc_pkg::WIDTH_BIT];
                tcc_pkg::ADDR_PRESCALE: next_r.presc_sel = I_APB_REQ.pwdata[3:0];
                tcc_pkg::ADDR_CAP_CTRL: next_r.cap_cfg = I_APB_REQ.pwdata[3:0];
                tcc_pkg::ADDR_EDGE: next_r.edge_cfg = I_APB_REQ.pwdata[3:0];
                tcc_pkg::ADDR_CMP_A: next_r.cmp_a = I_APB_REQ.pwdata[15:0];
                tcc_pkg::ADDR_CMP_B: next_r.cmp_b = I_APB_REQ.pwdata[15:0];
                tcc_pkg::ADDR_STATUS: st_clr = I_APB_REQ.pwdata[3:0];
                default: ; // read-only or unmapped words ignore writes
            endcase
        end
        next_r.full_flag = set_full | (r.full_flag & ~flag_clr);
        next_r.status = st_set | (r.status & ~st_clr);

        // --- read data is fetched in the access cycle before pready
        case (I_APB_REQ.paddr)
            tcc_pkg::ADDR_CTRL_ONE: begin
                rdata[tcc_pkg::RUN_BIT] = r.run;
                rdata[tcc_pkg::SHOT_BIT] = r.one_shot;
                rdata[tcc_pkg::FULL_BIT] = r.full_flag;
            end
            tcc_pkg::ADDR_CTRL_TWO: rdata[tcc_pkg::WIDTH_BIT] = r.wide;
            tcc_pkg::ADDR_PRESCALE: rdata[3:0] = r.presc_sel;
            tcc_pkg::ADDR_CAP_CTRL: rdata[3:0] = r.cap_cfg;
            tcc_pkg::ADDR_EDGE: rdata[3:0] = r.edge_cfg;
            tcc_pkg::ADDR_CMP_A: rdata[15:0] = r.cmp_a;
            tcc_pkg::ADDR_CMP_B: rdata[15:0] = r.cmp_b;
            tcc_pkg::ADDR_CAP_C: rdata[15:0] = r.cap_c;
            tcc_pkg::ADDR_COUNT: rdata[15:0] = r.count;
            tcc_pkg::ADDR_STATUS: rdata[3:0] = r.status;
            default: known = 1'b0;
        endcase
        next_r.rsp.pready = rd; // one wait state, pulse
        if (rd) begin
            next_r.rsp.prdata = I_APB_REQ.pwrite ? 32'h0000_0000 : rdata;
            next_r.rsp.pslverr = ~known;
        end else begin
            next_r.rsp.prdata = 32'h0000_0000;
            next_r.rsp.pslverr = 1'b0;
        end
    end

    // ======================================================================
    // state register; reset leaves everything zero and stopped
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ======================================================================
    // outputs straight from the state register
    assign O_APB_RSP = r.rsp;
    assign O_EVENTS = r.evt;
    assign O_TIMER_COUNT = r.count;
endmodule

/* bench/tcc_timer_monitor.sv */
// Purpose: port assertions of the capture/compare timer
// Assumes: one clock domain, async active-high reset
// Notes: bound from the bench top file
module tcc_timer_monitor #(
    parameter int PRESC_W = 11
) (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire tcc_pkg::tcc_apb_req_t I_APB_REQ,
    input wire tcc_pkg::tcc_apb_rsp_t O_APB_RSP,
    input wire logic I_EVENT_CLOCK_IN,
    input wire logic I_CAPTURE_TRIGGER_PIN_C,
    input wire tcc_pkg::tcc_evt_t O_EVENTS,
    input wire logic [15:0] O_TIMER_COUNT
);
    timeunit 1ns;
    timeprecision 1ps;
    // ======================================================================
    // properties
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);
    // accepted write that clears the run bit
    sequence s_stop_wr;
        I_APB_REQ.psel && I_APB_REQ.penable && O_APB_RSP.pready && I_APB_REQ.pwrite
        && I_APB_REQ.paddr == tcc_pkg::ADDR_CTRL_ONE
        && !I_APB_REQ.pwdata[tcc_pkg::RUN_BIT];
    endsequence
    // counter sits at zero for two cycles
    sequence s_zero_held;
        (O_TIMER_COUNT == tcc_pkg::CNT_ZERO) [*2];
    endsequence
    a_stop_zero: assert property (s_stop_wr |-> ##[1:2] s_zero_held)
        else $error("count not zero after stop");
    // reset check ignores the default disable on purpose
    a_reset_zero: assert property (disable iff (1'b0)
        I_SYS_RST |-> O_TIMER_COUNT == tcc_pkg::CNT_ZERO && O_EVENTS == '0)
        else $error("outputs not zero in reset");
    // the count only steps by one or returns to zero
    a_count_step: assert property ($changed(O_TIMER_COUNT) |->
        O_TIMER_COUNT == tcc_pkg::CNT_ZERO
        || O_TIMER_COUNT == $past(O_TIMER_COUNT) + tcc_pkg::CNT_ONE)
        else $error("count jumped");
    a_irq_a_pair: assert property (O_EVENTS.match_a == O_EVENTS.irq_a)
        else $error("match a and its request apart");
    a_irq_b_pair: assert property (O_EVENTS.match_b == O_EVENTS.irq_b)
        else $error("match b and its request apart");
    a_full_value: assert property (O_EVENTS.full |->
        O_TIMER_COUNT == tcc_pkg::CNT_ZERO || O_TIMER_COUNT[7:0] == 8'hFF)
        else $error("full notice at odd count");
    a_ext_pulse: assert property (O_EVENTS.ext_b |=> !O_EVENTS.ext_b)
        else $error("event request longer than a cycle");
    a_rdy_pulse: assert property (O_APB_RSP.pready |=> !O_APB_RSP.pready)
        else $error("pready held");
endmodule

/* bench/tcc_pins_model.sv */
// Purpose: drives the event pin and the capture pin
// Assumes: called from the bench just after a clock edge
// Notes: levels change only on rising edges
module tcc_pins_model (
    input wire logic i_clk,
    output logic o_pin_b = 1'b0,
    output logic o_pin_c = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // ======================================================================
    // six clocks per level: above the minimum, period well under clk/8
    task automatic pulse_b(input int n);
        repeat (n) begin
            @(posedge i_clk);
            o_pin_b <= 1'b1;
            repeat (6) @(posedge i_clk);
            o_pin_b <= 1'b0;
            repeat (5) @(posedge i_clk);
        end
    endtask
    // capture pin level change, then held
    task automatic set_c(input logic v);
        @(posedge i_clk);
        o_pin_c <= v;
        repeat (6) @(posedge i_clk);
    endtask
endmodule

/* bench/tcc_timer_bench.sv */
// Purpose: self-checking bench of the capture/compare timer
// Assumes: fastest prescale (divide 8) keeps the run short
// Notes: expected values come from the count rules only
module tcc_timer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // ======================================================================
    // clock, reset and wiring
    logic clk = 1'b0; // 25 MHz system clock
    logic rst = 1'b0; // raised at time zero so the asynchronous reset sees an edge
    tcc_pkg::tcc_apb_req_t req = '0;
    tcc_pkg::tcc_apb_rsp_t rsp;
    tcc_pkg::tcc_evt_t ev;
    logic [15:0] cnt;
    logic pin_b;
    logic pin_c;
    logic [31:0] q; // last read data
    logic err; // last slave error
    int fail_count = 0;
    int tests_run = 0;
    always #20 clk = ~clk;
    tcc_timer DUT (
        .I_CLK(clk),
        .I_SYS_RST(rst),
        .I_APB_REQ(req),
        .O_APB_RSP(rsp),
        .I_EVENT_CLOCK_IN(pin_b),
        .I_CAPTURE_TRIGGER_PIN_C(pin_c),
        .O_EVENTS(ev),
        .O_TIMER_COUNT(cnt)
    );
    tcc_pins_model pins (.i_clk(clk), .o_pin_b(pin_b), .o_pin_c(pin_c));
    // ======================================================================
    // shared tasks
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // a wait that ran out ends the run
    task automatic hang();
        fail_count++;
        $display("Error at %0t: wait ran out", $time);
        print_verdict();
    endtask
    // one apb transfer; the slave's answer time is not assumed
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (rsp.pready !== 1'b1) hang();
        q = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    // wait for any event pulse in the mask
    task automatic wait_ev(input logic [6:0] mask, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((ev & mask) === 7'h00 && n < lim);
        if ((ev & mask) === 7'h00) hang();
    endtask
    // ======================================================================
    // scenarios
    task automatic t_reset();
        rd(tcc_pkg::ADDR_CTRL_ONE, 32'h0);
        rd(tcc_pkg::ADDR_CMP_A, 32'h0);
        rd(tcc_pkg::ADDR_CAP_C, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk(err, 1'b1);
        chk(cnt, 16'h0000);
    endtask
    // start, rewrite run while running, then stop
    task automatic t_run();
        logic [31:0] c1;
        wr(tcc_pkg::ADDR_CTRL_ONE, 32'h08);
        repeat (100) @(posedge clk);
        apb(1'b0, tcc_pkg::ADDR_COUNT, 32'h0);
        c1 = q;
        chk(c1 > 32'h4 && c1 < 32'hFF, 1'b1);
        wr(tcc_pkg::ADDR_CTRL_ONE, 32'h08);
        apb(1'b0, tcc_pkg::ADDR_COUNT, 32'h0);
        chk(q >= c1 && q <= c1 + 32'h2, 1'b1);
        wr(tcc_pkg::ADDR_CTRL_ONE, 32'h00);
        repeat (2) @(posedge clk);
        chk(cnt, 16'h0000);
        repeat (40) @(posedge clk);
        chk(cnt, 16'h0000);
    endtask
    // clear on match a: a repeating interval of four ticks
    task automatic t_match();
        wr(tcc_pkg::ADDR_CMP_A, 32'h3);
        wr(tcc_pkg::ADDR_CMP_B, 32'h2);
        wr(tcc_pkg::ADDR_CAP_CTRL, 32'h8);
        wr(tcc_pkg::ADDR_STATUS, 32'hF);
        wr(tcc_pkg::ADDR_CTRL_ONE, 32'h08);
        wait_ev(7'h40, 200);
        chk(cnt, 16'h0003);
        wait_ev(7'h40, 40);
        chk(cnt, 16'h0003);
        apb(1'b0, tcc_pkg::ADDR_STATUS, 32'h0);
        chk(q[tcc_pkg::ST_MATCH_A], 1'b1);
        chk(q[tcc_pkg::ST_MATCH_B], 1'b1);
        wr(tcc_pkg::ADDR_CTRL_ONE, 32'h00);
        wr(tcc_pkg::ADDR_CAP_CTRL, 32'h0);
    endtask
    // single shot in 8-bit width: halt at all-ones, restart on flag clear
    task automatic t_shot();
        wr(tcc_pkg::ADDR_CTRL_ONE, 32'h28);
        wait_ev(7'h04, 3000);
        repeat (40) @(posedge clk);
        chk(cnt, 16'h00FF);
        rd(tcc_pkg::ADDR_CTRL_ONE, 32'h68);
        wr(tcc_pkg::ADDR_CTRL_ONE, 32'h28);
        repeat (30) @(posedge clk);
        chk(cnt > 16'h0000 && cnt < 16'h0008, 1'b1);
        wr(tcc_pkg::ADDR_CTRL_ONE, 32'h00);
    endtask
    // event counting on pin b, capture on both edges of pin c
    task automatic t_event();
        wr(tcc_pkg::ADDR_PRESCALE, 32'hF);
        wr(tcc_pkg::ADDR_EDGE, 32'h9);
        wr(tcc_pkg::ADDR_STATUS, 32'hF);
        wr(tcc_pkg::ADDR_CTRL_ONE, 32'h08);
        pins.pulse_b(5);
        repeat (8) @(posedge clk);
        chk(cnt, 16'h0004);
        apb(1'b0, tcc_pkg::ADDR_STATUS, 32'h0);
        chk(q[tcc_pkg::ST_EXT_B], 1'b1);
        pins.set_c(1'b1);
        repeat (8) @(posedge clk);
        rd(tcc_pkg::ADDR_CAP_C, 32'h4);
        pins.pulse_b(2);
        repeat (8) @(posedge clk);
        rd(tcc_pkg::ADDR_CAP_C, 32'h4);
        pins.set_c(1'b0);
        repeat (8) @(posedge clk);
        rd(tcc_pkg::ADDR_CAP_C, 32'h6);
        apb(1'b0, tcc_pkg::ADDR_STATUS, 32'h0);
        chk(q[tcc_pkg::ST_EXT_C], 1'b1);
    endtask
    // dual register b captures on pin b, then the count is cleared
    task automatic t_capb();
        logic [31:0] c1;
        wr(tcc_pkg::ADDR_CTRL_ONE, 32'h00);
        wr(tcc_pkg::ADDR_PRESCALE, 32'h0);
        wr(tcc_pkg::ADDR_CAP_CTRL, 32'h3);
        wr(tcc_pkg::ADDR_CTRL_ONE, 32'h08);
        repeat (60) @(posedge clk);
        pins.pulse_b(1);
        apb(1'b0, tcc_pkg::ADDR_CMP_B, 32'h0);
        c1 = q;
        chk(c1 > 32'h5 && c1 < 32'h9, 1'b1);
        apb(1'b0, tcc_pkg::ADDR_COUNT, 32'h0);
        chk(q < 32'h3, 1'b1);
    endtask
    // normal wrap at 8 bits, then no wrap past 255 at 16 bits
    task automatic t_wrap();
        wr(tcc_pkg::ADDR_CTRL_ONE, 32'h00);
        wr(tcc_pkg::ADDR_CAP_CTRL, 32'h0);
        wr(tcc_pkg::ADDR_CTRL_ONE, 32'h08);
        wait_ev(7'h04, 2200);
        chk(cnt, 16'h0000);
        rd(tcc_pkg::ADDR_CTRL_ONE, 32'h48);
        wr(tcc_pkg::ADDR_CTRL_TWO, 32'h1);
        wr(tcc_pkg::ADDR_CTRL_ONE, 32'h00);
        wr(tcc_pkg::ADDR_CTRL_ONE, 32'h08);
        repeat (2200) @(posedge clk);
        chk(cnt > 16'h00FF, 1'b1);
    endtask
    // ======================================================================
    // main sequence
    initial begin
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_run();
        t_match();
        t_shot();
        t_event();
        t_capb();
        t_wrap();
        print_verdict();
    end
endmodule
bind tcc_timer tcc_timer_monitor #(.PRESC_W(PRESC_W)) u_mon (
    .I_CLK(I_CLK),
    .I_SYS_RST(I_SYS_RST),
    .I_APB_REQ(I_APB_REQ),
    .O_APB_RSP(O_APB_RSP),
    .I_EVENT_CLOCK_IN(I_EVENT_CLOCK_IN),
    .I_CAPTURE_TRIGGER_PIN_C(I_CAPTURE_TRIGGER_PIN_C),
    .O_EVENTS(O_EVENTS),
    .O_TIMER_COUNT(O_TIMER_COUNT)
);
